// File: core/hpiad_decoder.sv
`timescale 1ns/1ps
module hpiad_decoder
  import hpiad_pkg::*;
#(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              arst_n_i,
  // processor request, same clock domain
  input  wire logic              cpu_req_i,
  input  wire logic              cpu_rd_i,
  input  wire logic [ADDR_W-1:0] cpu_addr_i,
  // mode controls: software setting and board strap pin
  input  wire logic              discontig_i,
  input  wire logic              alt_map_sw_i,
  input  wire logic              alt_map_strap_i,
  // pci target side request
  input  wire logic              pci_req_i,
  input  wire logic              pci_io_i,
  input  wire logic [ADDR_W-1:0] pci_addr_i,
  // interrupt acknowledge answer from pci
  input  wire logic              iack_done_i,
  input  wire logic [DATA_W-1:0] iack_vector_i,
  // processor outputs
  output logic                   dram_sel_o,
  output logic [ADDR_W-1:0]      dram_addr_o,
  output logic                   pci_start_o,
  output hpiad_pkg::hpiad_cyc_t  pci_cyc_o,
  output logic [ADDR_W-1:0]      pci_addr_o,
  output logic [HPIAD_IDSEL_W-1:0] pci_idsel_o,
  output logic                   flash_sel_o,
  output logic                   flash_bank_o,
  output logic                   cfg_addr_sel_o,
  output logic                   cfg_data_sel_o,
  output logic [3:0]             board_sel_o,
  output logic                   clock_nvram_addr_low_strobe_o,
  output logic                   clock_nvram_addr_high_strobe_o,
  output logic                   clock_nvram_data_sel_o,
  output logic                   cpu_rdata_valid_o,
  output logic [DATA_W-1:0]      cpu_rdata_o,
  output logic                   alt_map_o,
  // pci-to-dram target outputs
  output logic                   pci_claim_o,
  output logic [ADDR_W-1:0]      pci_dram_addr_o
);
  import hpiad_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_s1_r, rst_n_r;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ------------------------------------------------------------
  // strap synchroniser and map select
  // ------------------------------------------------------------
  // strap is a pin, two flops before use
  logic strap_s1_r, strap_s2_r;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_s1_r <= 1'b0;
      strap_s2_r <= 1'b0;
    end else begin
      strap_s1_r <= alt_map_strap_i;
      strap_s2_r <= strap_s1_r;
    end
  end

  // default map at reset
  // the alternate map is only flagged; its layout is unsupported here
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) alt_map_o <= 1'b0;
    else          alt_map_o <= strap_s2_r | alt_map_sw_i;
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // discontiguous io offset back to the isa port
  function automatic logic [15:0] disc_port(input logic [23:0] off);
    disc_port = {off[22:12], off[4:0]};
  endfunction

  hpiad_tgt_t  tgt;
  logic [31:0] a;
  logic [15:0] isa_port;
  logic        isa_hit;
  always_comb begin
    a = cpu_addr_i[31:0];
    if (a <= HPIAD_DRAM_END)                                tgt = HPIAD_T_DRAM;
    else if (in_rng(a, HPIAD_IO_LO_BASE, HPIAD_IO_LO_END))  tgt = HPIAD_T_PCI_IO;
    else if (in_rng(a, HPIAD_CFG_BASE, HPIAD_CFG_END))      tgt = HPIAD_T_PCI_CFG;
    else if (in_rng(a, HPIAD_IO_HI_BASE, HPIAD_IO_HI_END))  tgt = HPIAD_T_PCI_IO;
    else if (in_rng(a, HPIAD_RSV_BASE, HPIAD_RSV_END))      tgt = HPIAD_T_PCI_IO;
    else if (in_rng(a, HPIAD_IACK_BASE, HPIAD_IACK_END))
      tgt = cpu_rd_i ? HPIAD_T_PCI_IACK : HPIAD_T_PCI_IO;
    else if (in_rng(a, HPIAD_MEM_BASE, HPIAD_MEM_END))      tgt = HPIAD_T_PCI_MEM;
    // flash repeats across the top 16 MB
    else                                                    tgt = HPIAD_T_FLASH;
    // mode picks how the isa port is found
    isa_port = discontig_i ? disc_port(a[23:0]) : a[15:0];
    isa_hit  = cpu_req_i && in_rng(a, HPIAD_IO_LO_BASE, HPIAD_IO_LO_END);
  end

  // ------------------------------------------------------------
  // onboard isa port decode
  // ------------------------------------------------------------
  logic       cfg_a_c, cfg_d_c, rtc_lo_c, rtc_hi_c, rtc_d_c;
  logic [3:0] brd_c;
  hpiad_isa_decode u_isa (
    .port_i                         (isa_port),
    .valid_i                        (isa_hit),
    .cfg_addr_sel_o                 (cfg_a_c),
    .cfg_data_sel_o                 (cfg_d_c),
    .board_sel_o                    (brd_c),
    .clock_nvram_addr_low_strobe_o  (rtc_lo_c),
    .clock_nvram_addr_high_strobe_o (rtc_hi_c),
    .clock_nvram_data_sel_o         (rtc_d_c)
  );

  // ------------------------------------------------------------
  // registered processor-side outputs
  // ------------------------------------------------------------
  // one request per cycle; all selects stand for one cycle
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      dram_sel_o  <= 1'b0;
      dram_addr_o <= '0;
      pci_start_o <= 1'b0;
      pci_cyc_o   <= HPIAD_C_IO;
      pci_addr_o  <= '0;
      pci_idsel_o <= '0;
      flash_sel_o <= 1'b0;
      flash_bank_o <= 1'b0;
    end else begin
      // nothing asserted without a matching request
      dram_sel_o  <= cpu_req_i && (tgt == HPIAD_T_DRAM);
      flash_sel_o <= cpu_req_i && (tgt == HPIAD_T_FLASH);
      // dram never starts a pci cycle
      pci_start_o <= cpu_req_i && (tgt != HPIAD_T_DRAM) && (tgt != HPIAD_T_FLASH);
      // bank from bit 19 of each megabyte
      flash_bank_o <= a[HPIAD_FLASH_BANK_BIT];
      dram_addr_o <= cpu_addr_i;
      // window offsets removed by the top two bits
      pci_addr_o  <= {2'b00, cpu_addr_i[ADDR_W-3:0]};
      unique case (tgt)
        HPIAD_T_PCI_CFG:  pci_cyc_o <= HPIAD_C_CFG;
        HPIAD_T_PCI_MEM:  pci_cyc_o <= HPIAD_C_MEM;
        HPIAD_T_PCI_IACK: pci_cyc_o <= HPIAD_C_IACK;
        default:          pci_cyc_o <= HPIAD_C_IO;
      endcase
      // select lines follow address bits 11..18
      pci_idsel_o <= (cpu_req_i && tgt == HPIAD_T_PCI_CFG) ?
                     cpu_addr_i[HPIAD_IDSEL_HI:HPIAD_IDSEL_LO] : '0;
    end
  end

  // onboard port selects, registered
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_addr_sel_o                 <= 1'b0;
      cfg_data_sel_o                 <= 1'b0;
      board_sel_o                    <= '0;
      clock_nvram_addr_low_strobe_o  <= 1'b0;
      clock_nvram_addr_high_strobe_o <= 1'b0;
      clock_nvram_data_sel_o         <= 1'b0;
    end else begin
      cfg_addr_sel_o                 <= cfg_a_c;
      cfg_data_sel_o                 <= cfg_d_c;
      board_sel_o                    <= brd_c;
      clock_nvram_addr_low_strobe_o  <= rtc_lo_c;
      clock_nvram_addr_high_strobe_o <= rtc_hi_c;
      clock_nvram_data_sel_o         <= rtc_d_c;
    end
  end

  // ------------------------------------------------------------
  // interrupt acknowledge read return
  // ------------------------------------------------------------
  // vector handed back as read data
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cpu_rdata_valid_o <= 1'b0;
      cpu_rdata_o       <= HPIAD_RESET_DATA[DATA_W-1:0];
    end else begin
      cpu_rdata_valid_o <= iack_done_i;
      if (iack_done_i) cpu_rdata_o <= iack_vector_i;
    end
  end

  // ------------------------------------------------------------
  // pci target claim toward dram
  // ------------------------------------------------------------
  // only memory at 2 GB and above is claimed
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pci_claim_o     <= 1'b0;
      pci_dram_addr_o <= '0;
    end else begin
      pci_claim_o     <= pci_req_i && !pci_io_i && pci_addr_i[ADDR_W-1];
      pci_dram_addr_o <= {1'b0, pci_addr_i[ADDR_W-2:0]};
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_dram_no_pci;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (cpu_req_i && cpu_addr_i[31] == 1'b0) |=> (dram_sel_o && !pci_start_o);
  endproperty
  a_dram_no_pci: assert property (p_dram_no_pci) else $error("dram access reached pci");

  property p_io_lo;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (cpu_req_i && in_rng(cpu_addr_i, HPIAD_IO_LO_BASE, HPIAD_IO_LO_END))
        |=> (pci_cyc_o == HPIAD_C_IO && pci_addr_o == ($past(cpu_addr_i) - HPIAD_IO_LO_BASE));
  endproperty
  a_io_lo: assert property (p_io_lo) else $error("low io translation wrong");

  property p_cfg;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (cpu_req_i && in_rng(cpu_addr_i, HPIAD_CFG_BASE, HPIAD_CFG_END))
        |=> (pci_start_o && pci_cyc_o == HPIAD_C_CFG);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config window not a config cycle");

  property p_mem;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (cpu_req_i && in_rng(cpu_addr_i, HPIAD_MEM_BASE, HPIAD_MEM_END))
        |=> (pci_cyc_o == HPIAD_C_MEM && pci_addr_o == ($past(cpu_addr_i) - HPIAD_MEM_BASE));
  endproperty
  a_mem: assert property (p_mem) else $error("memory translation wrong");

  property p_flash;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (cpu_req_i && cpu_addr_i[31:24] == 8'hFF)
        |=> (flash_sel_o && !pci_start_o && flash_bank_o == $past(cpu_addr_i[19]));
  endproperty
  a_flash: assert property (p_flash) else $error("flash bank select wrong");

  sequence s_iack_rd;
    cpu_req_i && cpu_rd_i && cpu_addr_i[31:4] == 28'hBFFF_FFF;
  endsequence
  property p_iack;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      s_iack_rd |=> (pci_start_o && pci_cyc_o == HPIAD_C_IACK);
  endproperty
  a_iack: assert property (p_iack) else $error("iack cycle not launched");

  property p_idsel;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (cpu_req_i && in_rng(cpu_addr_i, HPIAD_CFG_BASE, HPIAD_CFG_END))
        |=> (pci_idsel_o == $past(cpu_addr_i[18:11]));
  endproperty
  a_idsel: assert property (p_idsel) else $error("device select lines wrong");

  property p_claim;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (pci_req_i && (pci_io_i || !pci_addr_i[31])) |=> !pci_claim_o;
  endproperty
  a_claim: assert property (p_claim) else $error("illegal pci claim");

  property p_idle;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      !cpu_req_i |=> (!dram_sel_o && !flash_sel_o && !pci_start_o && board_sel_o == 4'h0);
  endproperty
  a_idle: assert property (p_idle) else $error("select without request");

  property p_rtc;
    @(posedge clk_sys_i) disable iff (!rst_n_r)
      (cpu_req_i && !discontig_i && cpu_addr_i == 32'h8000_0074) |=> clock_nvram_addr_low_strobe_o;
  endproperty
  a_rtc: assert property (p_rtc) else $error("clock strobe missing");
endmodule // hpiad_decoder

// File: core/hpiad_pkg.sv
package hpiad_pkg;

  // ------------------------------------------------------------
  // processor-side windows
  // ------------------------------------------------------------
  localparam logic [31:0] HPIAD_DRAM_END      = 32'h7FFF_FFFF;
  localparam logic [31:0] HPIAD_IO_LO_BASE    = 32'h8000_0000;
  localparam logic [31:0] HPIAD_IO_LO_END     = 32'h807F_FFFF;
  localparam logic [31:0] HPIAD_CFG_BASE      = 32'h8080_0000;
  localparam logic [31:0] HPIAD_CFG_END       = 32'h80FF_FFFF;
  localparam logic [31:0] HPIAD_IO_HI_BASE    = 32'h8100_0000;
  localparam logic [31:0] HPIAD_IO_HI_END     = 32'hBF7F_FFFF;
  localparam logic [31:0] HPIAD_RSV_BASE      = 32'hBF80_0000;
  localparam logic [31:0] HPIAD_RSV_END       = 32'hBFFF_FFEF;
  localparam logic [31:0] HPIAD_IACK_BASE     = 32'hBFFF_FFF0;
  localparam logic [31:0] HPIAD_IACK_END      = 32'hBFFF_FFFF;
  localparam logic [31:0] HPIAD_MEM_BASE      = 32'hC000_0000;
  localparam logic [31:0] HPIAD_MEM_END       = 32'hFEFF_FFFF;
  localparam logic [31:0] HPIAD_FLASH_BASE    = 32'hFF00_0000;
  localparam int          HPIAD_FLASH_BANK_BIT = 19;

  // ------------------------------------------------------------
  // indirect configuration ports and onboard isa ports
  // ------------------------------------------------------------
  localparam logic [15:0] HPIAD_PORT_CFG_ADDR = 16'h0CF8;
  localparam logic [15:0] HPIAD_PORT_CFG_DATA = 16'h0CFC;
  localparam logic [15:0] HPIAD_PORT_CPU_TYPE = 16'h0800;
  localparam logic [15:0] HPIAD_PORT_SYS_CFG  = 16'h0802;
  localparam logic [15:0] HPIAD_PORT_MEM_SIZE = 16'h0804;
  localparam logic [15:0] HPIAD_PORT_PWR_CTL  = 16'h0807;
  localparam logic [15:0] HPIAD_PORT_RTC_LO   = 16'h0074;
  localparam logic [15:0] HPIAD_PORT_RTC_HI   = 16'h0075;
  localparam logic [15:0] HPIAD_PORT_RTC_DATA = 16'h0077;

  // ------------------------------------------------------------
  // direct-mapped configuration select span
  // ------------------------------------------------------------
  localparam int          HPIAD_IDSEL_LO      = 11;
  localparam int          HPIAD_IDSEL_HI      = 18;
  localparam int          HPIAD_IDSEL_W       = 8;
  localparam int          HPIAD_IACK_LAT      = 1;
  localparam logic [31:0] HPIAD_RESET_DATA    = 32'h0000_0000;

  // decoded processor target
  typedef enum logic [3:0] {
    HPIAD_T_NONE, HPIAD_T_DRAM, HPIAD_T_PCI_IO, HPIAD_T_PCI_CFG,
    HPIAD_T_PCI_IACK, HPIAD_T_PCI_MEM, HPIAD_T_FLASH
  } hpiad_tgt_t;

  // pci cycle kind
  typedef enum logic [1:0] {
    HPIAD_C_IO, HPIAD_C_CFG, HPIAD_C_MEM, HPIAD_C_IACK
  } hpiad_cyc_t;

endpackage

// File: core/hpiad_isa_decode.sv
`timescale 1ns/1ps
// isa port decode for onboard functions, combinational
module hpiad_isa_decode
  import hpiad_pkg::*;
(
  // port number
  input  wire logic [15:0] port_i,
  input  wire logic        valid_i,
  // onboard selects
  output logic             cfg_addr_sel_o,
  output logic             cfg_data_sel_o,
  output logic [3:0]       board_sel_o,
  output logic             clock_nvram_addr_low_strobe_o,
  output logic             clock_nvram_addr_high_strobe_o,
  output logic             clock_nvram_data_sel_o
);
  import hpiad_pkg::*;

  // ------------------------------------------------------------
  // port compare
  // ------------------------------------------------------------
  // board and clock ports match exactly, the two config ports match any byte of their four-byte word; all others stay off the board
  always_comb begin
    cfg_addr_sel_o                 = valid_i && (port_i[15:2] == HPIAD_PORT_CFG_ADDR[15:2]);
    cfg_data_sel_o                 = valid_i && (port_i[15:2] == HPIAD_PORT_CFG_DATA[15:2]);
    board_sel_o[0]                 = valid_i && (port_i == HPIAD_PORT_CPU_TYPE);
    board_sel_o[1]                 = valid_i && (port_i == HPIAD_PORT_SYS_CFG);
    board_sel_o[2]                 = valid_i && (port_i == HPIAD_PORT_MEM_SIZE);
    board_sel_o[3]                 = valid_i && (port_i == HPIAD_PORT_PWR_CTL);
    clock_nvram_addr_low_strobe_o  = valid_i && (port_i == HPIAD_PORT_RTC_LO);
    clock_nvram_addr_high_strobe_o = valid_i && (port_i == HPIAD_PORT_RTC_HI);
    clock_nvram_data_sel_o         = valid_i && (port_i == HPIAD_PORT_RTC_DATA);
  end
endmodule // hpiad_isa_decode

// File: sim/hpiad_pci_model.sv
`timescale 1ns/1ps
// far side of the pci bus, answering interrupt acknowledge cycles
module hpiad_pci_model
  import hpiad_pkg::*;
(
  // clock
  input  wire logic             clk_sys_i,
  // cycle seen from the bridge
  input  wire logic             pci_start_i,
  input  hpiad_pkg::hpiad_cyc_t pci_cyc_i,
  // pace and vector set by the bench
  input  wire logic             slow_i,
  input  wire logic [31:0]      vector_i,
  // acknowledge answer
  output logic                  iack_done_o,
  output logic [31:0]           iack_vector_o
);
  import hpiad_pkg::*;

  initial begin
    iack_done_o   = 1'b0;
    iack_vector_o = 32'h0;
  end

  // vector on acknowledge
  // answer one or six cycles late; slow replies catch a decoder that only waits one
  always begin
    @(posedge clk_sys_i) #1;
    if (pci_start_i === 1'b1 && pci_cyc_i === HPIAD_C_IACK) begin
      repeat (slow_i ? 6 : 1) @(posedge clk_sys_i) #1;
      iack_done_o   = 1'b1;
      iack_vector_o = vector_i;
      @(posedge clk_sys_i) #1;
      iack_done_o   = 1'b0;
      iack_vector_o = ~iack_vector_o; // released: never leave a stale vector
    end
  end
endmodule // hpiad_pci_model

// File: sim/host_pci_isa_address_decoder_bench.sv
`timescale 1ns/1ps
module host_pci_isa_address_decoder_bench;
  import hpiad_pkg::*;
  // ----
  // stimulus and observed outputs
  // ----
  logic        clk_sys_i, arst_n_i, cpu_req_i, cpu_rd_i, discontig_i, slow;
  logic        alt_map_sw_i, alt_map_strap_i, pci_req_i, pci_io_i, iack_done_i;
  logic [31:0] cpu_addr_i, pci_addr_i, iack_vector_i, vec, dram_addr_o;
  logic [31:0] pci_addr_o, cpu_rdata_o, pci_dram_addr_o;
  logic        dram_sel_o, pci_start_o, flash_sel_o, flash_bank_o, cfg_addr_sel_o;
  logic        cfg_data_sel_o, cpu_rdata_valid_o, alt_map_o, pci_claim_o;
  logic        clock_nvram_addr_low_strobe_o, clock_nvram_addr_high_strobe_o;
  logic        clock_nvram_data_sel_o;
  logic [7:0]  pci_idsel_o;
  logic [3:0]  board_sel_o;
  hpiad_cyc_t  pci_cyc_o;
  int          error_cnt, checks;
  logic [15:0] ports [15] = '{16'h0800, 16'h0801, 16'h0802, 16'h0803, 16'h0804, 16'h0805,
    16'h0806, 16'h0807, 16'h0074, 16'h0075, 16'h0076, 16'h0077, 16'h0CF8, 16'h0CFC, 16'h02F8};

  hpiad_decoder u_dut (
    .clk_sys_i, .arst_n_i, .cpu_req_i, .cpu_rd_i, .cpu_addr_i, .discontig_i,
    .alt_map_sw_i, .alt_map_strap_i, .pci_req_i, .pci_io_i, .pci_addr_i, .iack_done_i,
    .iack_vector_i, .dram_sel_o, .dram_addr_o, .pci_start_o, .pci_cyc_o, .pci_addr_o,
    .pci_idsel_o, .flash_sel_o, .flash_bank_o, .cfg_addr_sel_o, .cfg_data_sel_o,
    .board_sel_o, .clock_nvram_addr_low_strobe_o, .clock_nvram_addr_high_strobe_o,
    .clock_nvram_data_sel_o, .cpu_rdata_valid_o, .cpu_rdata_o, .alt_map_o,
    .pci_claim_o, .pci_dram_addr_o);

  hpiad_pci_model u_pci (.clk_sys_i, .pci_start_i(pci_start_o), .pci_cyc_i(pci_cyc_o),
    .slow_i(slow), .vector_i(vec), .iack_done_o(iack_done_i), .iack_vector_o(iack_vector_i));

  // ----
  // shared tasks
  // ----
  task chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one processor request; outputs are settled on return
  task acc(input logic [31:0] a, input logic rd);
    @(posedge clk_sys_i) #1;
    cpu_req_i  = 1'b1;
    cpu_rd_i   = rd;
    cpu_addr_i = a;
    @(posedge clk_sys_i) #1;
    cpu_req_i  = 1'b0;
  endtask

  // k: 0 dram, 1 io, 2 config, 3 memory, 4 flash
  task win(input logic [31:0] a, input int k, input logic rd = 1'b1);
    acc(a, rd);
    chk(dram_sel_o, k == 0);
    chk(pci_start_o, k inside {1, 2, 3});
    chk(flash_sel_o, k == 4);
    if (k == 0) chk(dram_addr_o, a);
    if (k == 4) chk(flash_bank_o, a[19]);
    if (k inside {1, 2, 3}) begin
      chk(pci_cyc_o, k == 1 ? HPIAD_C_IO : k == 2 ? HPIAD_C_CFG : HPIAD_C_MEM);
      chk(pci_addr_o, a & 32'h3FFF_FFFF);
      chk(pci_idsel_o, k == 2 ? a[18:11] : 8'h00);
    end
  endtask

  task isa(input logic [15:0] p, input logic dis);
    discontig_i = dis;
    acc(dis ? {9'h100, p[15:5], 7'h0, p[4:0]} : {16'h8000, p}, 1'b1);
    chk(board_sel_o, {p == HPIAD_PORT_PWR_CTL, p == HPIAD_PORT_MEM_SIZE,
                      p == HPIAD_PORT_SYS_CFG, p == HPIAD_PORT_CPU_TYPE});
    chk({clock_nvram_addr_low_strobe_o, clock_nvram_addr_high_strobe_o, clock_nvram_data_sel_o},
        {p == HPIAD_PORT_RTC_LO, p == HPIAD_PORT_RTC_HI, p == HPIAD_PORT_RTC_DATA});
    chk({cfg_addr_sel_o, cfg_data_sel_o}, {p[15:2] == 14'h033E, p[15:2] == 14'h033F});
  endtask

  task iack(input logic [31:0] a, v, input logic s);
    int i;
    slow = s;
    vec  = v;
    acc(a, 1'b1);
    chk(pci_start_o, 1'b1);
    chk(pci_cyc_o, HPIAD_C_IACK);
    i = 0;
    while (cpu_rdata_valid_o !== 1'b1 && i < 20) begin
      @(posedge clk_sys_i) #1;
      i++;
    end
    chk(cpu_rdata_valid_o, 1'b1);
    chk(cpu_rdata_o, v);
  endtask

  task tgt(input logic [31:0] a, input logic io, claim);
    @(posedge clk_sys_i) #1;
    pci_req_i  = 1'b1;
    pci_io_i   = io;
    pci_addr_i = a;
    @(posedge clk_sys_i) #1;
    pci_req_i  = 1'b0;
    chk(pci_claim_o, claim);
    chk(dram_sel_o, 1'b0);
    if (claim) chk(pci_dram_addr_o, {1'b0, a[30:0]});
  endtask

  // ----
  // scenarios
  // ----
  task t_altmap;
    chk(alt_map_o, 1'b0);
    alt_map_strap_i = 1'b1;
    repeat (4) @(posedge clk_sys_i) #1;
    chk(alt_map_o, 1'b1);
    win(32'hC000_1000, 3);
    alt_map_strap_i = 1'b0;
    alt_map_sw_i    = 1'b1;
    repeat (4) @(posedge clk_sys_i) #1;
    chk(alt_map_o, 1'b1);
    alt_map_sw_i    = 1'b0;
  endtask

  task t_windows;
    win(32'h0000_0000, 0);
    win(32'h7FFF_FFFF, 0);
    win(32'h8000_0000, 1);
    win(32'h807F_FFFF, 1);
    win(32'h8080_0800, 2);
    win(32'h8080_8000, 2);
    win(32'h8080_10FF, 2);
    win(32'h8081_0000, 2);
    win(32'h8082_0000, 2);
    win(32'h8084_00FF, 2);
    win(32'h8100_0000, 1);
    win(32'hBF7F_FFFF, 1);
    win(32'hBF80_0000, 1);
    win(32'hBFFF_FFEF, 1);
    win(32'hBFFF_FFF8, 1, 1'b0);
    win(32'hC000_0000, 3);
    win(32'hFEFF_FFFF, 3);
    win(32'hFF00_0000, 4);
    win(32'hFF08_0000, 4);
    win(32'hFFF7_FFFF, 4);
    win(32'hFFF8_0000, 4);
  endtask

  task t_b2b;
    @(posedge clk_sys_i) #1;
    cpu_req_i  = 1'b1;
    cpu_addr_i = 32'hC000_0010;
    @(posedge clk_sys_i) #1;
    cpu_addr_i = 32'h0000_0040;
    chk(pci_addr_o, 32'h0000_0010);
    @(posedge clk_sys_i) #1;
    cpu_req_i  = 1'b0;
    chk({dram_sel_o, pci_start_o}, 2'b10);
  endtask

  task t_isa;
    for (int m = 0; m < 2; m++)
      foreach (ports[j]) isa(ports[j], m[0]);
  endtask

  // ----
  // clock, reset and sequence
  // ----
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    {arst_n_i, cpu_req_i, cpu_rd_i, discontig_i, alt_map_sw_i, alt_map_strap_i} = '0;
    {pci_req_i, pci_io_i, slow} = '0;
    {cpu_addr_i, pci_addr_i, vec} = '0;
    repeat (5) @(posedge clk_sys_i) #1;
    chk({dram_sel_o, pci_start_o, flash_sel_o, pci_claim_o}, 4'h0);
    arst_n_i = 1'b1;
    // release takes two internal flops; first request after the third edge
    repeat (3) @(posedge clk_sys_i) #1;
    t_altmap;
    t_windows;
    t_b2b;
    iack(32'hBFFF_FFF0, 32'h0000_00A5, 1'b0);
    iack(32'hBFFF_FFFF, 32'h5A00_0013, 1'b1);
    t_isa;
    tgt(32'h8000_0000, 1'b0, 1'b1);
    tgt(32'hFFFF_FFFC, 1'b0, 1'b1);
    tgt(32'h7FFF_FFFF, 1'b0, 1'b0);
    tgt(32'h8000_0000, 1'b1, 1'b0);
    finish_test;
  end

  // hang guard, far beyond the roughly 150 cycles the run needs
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    error_cnt++;
    finish_test;
  end

  task finish_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
endmodule // host_pci_isa_address_decoder_bench
